// ### design/mwc_edge_sync.sv
// Two-stage synchroniser with rising-edge detector for one source clock
`timescale 1ns/1ps
module mwc_edge_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic src_in,
   output logic      rise
);
   import mwc_pkg::*;

   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } mwc_sync_t;

   mwc_sync_t st_q;
   mwc_sync_t st_d;

   always_comb begin
      st_d      = st_q;
      st_d.meta = src_in;
      // First stage feeds only the second stage
      st_d.sync = st_q.meta;
      st_d.last = st_q.sync;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rise = st_q.sync & ~st_q.last;

endmodule : mwc_edge_sync

// ### design/mwc_top.sv
// Modulo wake-up counter: source select, prescaler, 16-bit counter, registers
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module mwc_top #(
   parameter int ADDR_W = 4
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [31:0]       wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [31:0]       rd_data,
   input  wire logic              ext_osc_clk,
   input  wire logic              low_power_1khz_clock,
   input  wire logic              internal_reference_clock,
   output logic                   match_irq,
   output logic                   toggle_output
);
   import mwc_pkg::*;

   typedef struct packed {
      logic [1:0]           source_select;
      logic [2:0]           divider_select;
      logic                 match_flag;
      logic                 match_irq_enable;
      logic                 toggle_enable;
      logic [15:0]          limit_value;
      logic [15:0]          limit_active;
      logic [15:0]          count_value;
      logic [MWC_PRE_W-1:0] presc_cnt;
      logic                 toggle_out;
      logic [31:0]          rd_data;
   } mwc_state_t;

   mwc_state_t st_q;
   mwc_state_t st_d;

   // Sampled source clocks
   logic [MWC_NUM_PIN_SRC-1:0] pin_src;
   logic [MWC_NUM_PIN_SRC-1:0] pin_rise;

   // Decoded bus access
   logic                 wr_ctrl;
   logic                 wr_limit;
   logic                 rd_hit_ctrl;
   logic                 rd_hit_limit;
   logic                 rd_hit_count;

   // Fields carried by a control write
   logic [1:0]           new_src;
   logic [2:0]           new_div;
   logic                 clr_flag;
   logic                 restart;

   // Prescaler and counter helpers
   logic                 src_tick;
   logic [MWC_PRE_W-1:0] div_ratio;
   logic [MWC_PRE_W-1:0] div_last;
   logic                 presc_tick;
   logic                 wrap;
   logic [31:0]          ctrl_view;

   assign pin_src[0] = ext_osc_clk;
   assign pin_src[1] = low_power_1khz_clock;
   assign pin_src[2] = internal_reference_clock;

   generate
      for (genvar g = 0; g < MWC_NUM_PIN_SRC; g++) begin : g_src
         mwc_edge_sync u_sync (
            .clk    (clk),
            .rst    (rst),
            .src_in (pin_src[g]),
            .rise   (pin_rise[g])
         );
      end
   endgenerate

   // Register decode
   always_comb begin
      wr_ctrl      = wr_en && (addr == ADDR_W'(MWC_OFS_CTRL));
      wr_limit     = wr_en && (addr == ADDR_W'(MWC_OFS_LIMIT));
      rd_hit_ctrl  = rd_en && (addr == ADDR_W'(MWC_OFS_CTRL));
      rd_hit_limit = rd_en && (addr == ADDR_W'(MWC_OFS_LIMIT));
      rd_hit_count = rd_en && (addr == ADDR_W'(MWC_OFS_COUNT));
   end

   // Control write fields
   always_comb begin
      new_src  = wr_data[MWC_SRC_HI:MWC_SRC_LO];
      new_div  = wr_data[MWC_DIV_HI:MWC_DIV_LO];
      clr_flag = wr_ctrl && wr_data[MWC_FLAG_B];
      restart  = wr_ctrl &&
                 ((new_src != st_q.source_select) || (new_div != st_q.divider_select));
   end

   // Source tick selection
   always_comb begin
      case (st_q.source_select)
         MWC_SRC_EXT: src_tick = pin_rise[0];
         MWC_SRC_LPO: src_tick = pin_rise[1];
         MWC_SRC_IRC: src_tick = pin_rise[2];
         MWC_SRC_BUS: src_tick = 1'b1;
         default:     src_tick = 1'b0;
      endcase
   end

   // Divide ratio lookup
   always_comb begin
      if (st_q.source_select[0]) begin
         div_ratio = MWC_DIV_DEC[st_q.divider_select];
      end else begin
         div_ratio = MWC_DIV_BIN[st_q.divider_select];
      end
      div_last = div_ratio - MWC_PRE_W'(1);
   end

   // Prescaler output and wrap detection
   always_comb begin
      // Prescaler runs only with nonzero code
      presc_tick = (st_q.divider_select != MWC_DIV_OFF) && src_tick &&
                   (st_q.presc_cnt == div_last);
      wrap       = presc_tick && (st_q.count_value == st_q.limit_active);
   end

   // Control register read view
   always_comb begin
      ctrl_view                         = '0;
      ctrl_view[MWC_SRC_HI:MWC_SRC_LO] = st_q.source_select;
      ctrl_view[MWC_DIV_HI:MWC_DIV_LO] = st_q.divider_select;
      ctrl_view[MWC_FLAG_B]             = st_q.match_flag;
      ctrl_view[MWC_IRQEN_B]            = st_q.match_irq_enable;
      ctrl_view[MWC_TOG_B]              = st_q.toggle_enable;
   end

   // Next-state logic
   always_comb begin
      st_d = st_q;

      // Control fields
      if (wr_ctrl) begin
         st_d.source_select    = new_src;
         st_d.divider_select   = new_div;
         st_d.match_irq_enable = wr_data[MWC_IRQEN_B];
         st_d.toggle_enable    = wr_data[MWC_TOG_B];
      end

      // Limit holding register
      if (wr_limit) begin
         st_d.limit_value = wr_data[15:0];
      end

      // Prescaler divider
      if (st_q.divider_select != MWC_DIV_OFF && src_tick) begin
         if (presc_tick) begin
            st_d.presc_cnt = '0;
         end else begin
            st_d.presc_cnt = st_q.presc_cnt + MWC_PRE_W'(1);
         end
      end

      // Counter step
      if (presc_tick) begin
         if (wrap) begin
            st_d.count_value = '0;
            st_d.limit_active = st_q.limit_value;
         end else begin
            st_d.count_value = st_q.count_value + 16'h0001;
         end
      end

      if (wrap && !restart && st_q.toggle_enable) begin
         st_d.toggle_out = ~st_q.toggle_out;
      end

      // Restart on source or divider change
      if (restart) begin
         st_d.presc_cnt   = '0;
         st_d.count_value = '0;
      end

      // Load limit when a nonzero code is selected
      if (wr_ctrl && new_div != MWC_DIV_OFF) begin
         st_d.limit_active = wr_limit ? wr_data[15:0] : st_q.limit_value;
      end

      if (clr_flag) begin
         st_d.match_flag = 1'b0;
      end
      // Flag on wrap, set beats clear
      if (wrap && !restart) begin
         st_d.match_flag = 1'b1;
      end

      // Read data stands for one cycle only
      // Count is read only
      st_d.rd_data = '0;
      if (rd_hit_ctrl) begin
         st_d.rd_data = ctrl_view;
      end else if (rd_hit_limit) begin
         st_d.rd_data = {16'h0000, st_q.limit_value};
      end else if (rd_hit_count) begin
         st_d.rd_data = {16'h0000, st_q.count_value};
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q.source_select    <= MWC_SRC_RST;
         st_q.divider_select   <= MWC_DIV_RST;
         st_q.match_flag       <= 1'b0;
         st_q.match_irq_enable <= 1'b0;
         st_q.toggle_enable    <= 1'b0;
         st_q.limit_value      <= MWC_LIMIT_RST;
         st_q.limit_active     <= MWC_LIMIT_RST;
         st_q.count_value      <= MWC_COUNT_RST;
         st_q.presc_cnt        <= '0;
         st_q.toggle_out       <= MWC_TOG_RST;
         st_q.rd_data          <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign match_irq     = st_q.match_flag & st_q.match_irq_enable;
   assign toggle_output = st_q.toggle_out;
   assign rd_data       = st_q.rd_data;

endmodule : mwc_top

// ### inc/mwc_pkg.sv
// Shared constants and types for the modulo wake-up counter
package mwc_pkg;

   // Register byte offsets
   localparam logic [3:0] MWC_OFS_CTRL  = 4'h0;
   localparam logic [3:0] MWC_OFS_LIMIT = 4'h4;
   localparam logic [3:0] MWC_OFS_COUNT = 4'h8;

   // Control register field positions
   localparam int MWC_SRC_LO  = 14;
   localparam int MWC_SRC_HI  = 15;
   localparam int MWC_DIV_LO  = 8;
   localparam int MWC_DIV_HI  = 10;
   localparam int MWC_FLAG_B  = 7;
   localparam int MWC_IRQEN_B = 6;
   localparam int MWC_TOG_B   = 4;

   // Reset values
   localparam logic [1:0]  MWC_SRC_RST   = 2'h0;
   localparam logic [2:0]  MWC_DIV_RST   = 3'h0;
   localparam logic [15:0] MWC_LIMIT_RST = 16'h0000;
   localparam logic [15:0] MWC_COUNT_RST = 16'h0000;
   localparam logic        MWC_TOG_RST   = 1'b1;

   // Divider code that stops the prescaler
   localparam logic [2:0] MWC_DIV_OFF = 3'h0;

   // Source select encodings
   localparam logic [1:0] MWC_SRC_EXT = 2'h0;
   localparam logic [1:0] MWC_SRC_LPO = 2'h1;
   localparam logic [1:0] MWC_SRC_IRC = 2'h2;
   localparam logic [1:0] MWC_SRC_BUS = 2'h3;

   // Number of pin-sampled sources (the bus clock needs no sampling)
   localparam int MWC_NUM_PIN_SRC = 3;

   // Prescaler width, large enough for the divide-by-2048 code
   localparam int MWC_PRE_W = 12;

   // Divide ratios indexed by divider code, source low bit clear
   localparam logic [7:0][MWC_PRE_W-1:0] MWC_DIV_BIN = {
      12'h040, 12'h020, 12'h010, 12'h008, 12'h004, 12'h002, 12'h001, 12'h001};

   // Divide ratios indexed by divider code, source low bit set
   localparam logic [7:0][MWC_PRE_W-1:0] MWC_DIV_DEC = {
      12'h3e8, 12'h064, 12'h800, 12'h400, 12'h200, 12'h100, 12'h080, 12'h001};

endpackage : mwc_pkg

// ### test/mwc_top_monitor.sv
// Port-level assertion checker for the wake-up counter
`timescale 1ns/1ps
module mwc_chk
   import mwc_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0]       wr_data,
   input wire logic              wr_en,
   input wire logic              rd_en,
   input wire logic [31:0]       rd_data,
   input wire logic              ext_osc_clk,
   input wire logic              low_power_1khz_clock,
   input wire logic              internal_reference_clock,
   input wire logic              match_irq,
   input wire logic              toggle_output
);
   logic [31:0]       ctl_q, ctl_p;
   logic [15:0]       lim_q, lim_p;
   logic              rd_q;
   logic [ADDR_W-1:0] ra_q;
   // Shadow of software-visible settings
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_q <= '0;
         lim_q <= '0;
      end else if (wr_en && addr == MWC_OFS_CTRL) begin
         ctl_q <= wr_data & 32'h0000c750;
      end else if (wr_en && addr == MWC_OFS_LIMIT) begin
         lim_q <= wr_data[15:0];
      end
   end
   always_ff @(posedge clk) begin
      rd_q  <= rd_en;
      ra_q  <= addr;
      ctl_p <= ctl_q;
      lim_p <= lim_q;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   rst_state_a: assert property (disable iff (1'b0)
      $past(rst) |-> toggle_output && !match_irq) else $error("bad reset state");
   rd_idle_a: assert property (!rd_q |-> rd_data == 32'h0)
      else $error("read data outside read slot");
   unmap_rd_a: assert property (rd_q && ra_q != MWC_OFS_CTRL && ra_q != MWC_OFS_LIMIT
      && ra_q != MWC_OFS_COUNT |-> rd_data == 32'h0) else $error("unmapped read not zero");
   lim_read_a: assert property (rd_q && ra_q == MWC_OFS_LIMIT
      |-> rd_data == {16'h0, lim_p}) else $error("limit readback wrong");
   ctl_read_a: assert property (rd_q && ra_q == MWC_OFS_CTRL
      |-> (rd_data & 32'hffffff7f) == ctl_p) else $error("control readback wrong");
   irq_gate_a: assert property (!ctl_q[MWC_IRQEN_B] |-> !match_irq)
      else $error("request while disabled");
   tog_gate_a: assert property ($changed(toggle_output)
      |-> ctl_p[MWC_TOG_B] && ctl_p[10:8] != 3'h0) else $error("toggle while disabled");
   // Pin sources give at most one synced edge every two cycles
   tog_gap_a: assert property ($changed(toggle_output) && ctl_p[15:14] != 2'h3
      |=> $stable(toggle_output)) else $error("pin source toggles on adjacent cycles");
endmodule : mwc_chk

bind mwc_top mwc_chk #(.ADDR_W(ADDR_W)) u_mwc_chk (.clk(clk), .rst(rst), .addr(addr),
   .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .ext_osc_clk(ext_osc_clk), .low_power_1khz_clock(low_power_1khz_clock),
   .internal_reference_clock(internal_reference_clock), .match_irq(match_irq),
   .toggle_output(toggle_output));

// ### test/tb_mwc_top.sv
// Self-checking bench for the wake-up counter
`timescale 1ns/1ps
module tb_mwc_top;
   import mwc_pkg::*;
   logic        clk = 0, rst = 1, wr_en = 0, rd_en = 0, irq, tog;
   logic [2:0]  pc = 0;
   logic [3:0]  addr = 0;
   logic [31:0] wr_data = 0, rd_data, v;
   int          errors = 0, checks_done = 0, cyc = 0, n, m;
   mwc_top u_mwc_top (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_osc_clk(pc[1]),
      .low_power_1khz_clock(pc[0]), .internal_reference_clock(pc[2]),
      .match_irq(irq), .toggle_output(tog));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // Source pins: ext period 4, low-power period 2, internal period 8
   always @(posedge clk) begin
      pc <= pc + 3'h1;
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         errors++;
         conclude();
      end
   end
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("FAIL %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rd_data;
   endtask : rd
   // Second interval between toggles is a full period
   task automatic per(output int p);
      logic t;
      repeat (2) begin
         t = tog;
         p = 0;
         while (tog === t && p < 25000) begin
            @(negedge clk);
            p++;
         end
      end
   endtask : per
   function automatic int exp_per(int s, int c, int l);
      int r;
      r = s[0] ? (c < 6 ? 64 << c : (c == 6 ? 100 : 1000)) : 1 << (c - 1);
      return r * (l + 1) * (s == 3 ? 1 : (s == 1 ? 2 : (s == 0 ? 4 : 8)));
   endfunction : exp_per
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   initial begin
      void'($urandom(14492));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i += 4) begin
         rd(4'(i));
         chk("reset reg", v, 0);
      end
      chk("reset pin", 32'(tog), 1);
      wr(4'h4, 32'hffffffff);
      rd(4'h4);
      chk("limit mask", v, 32'h0000ffff);
      wr(4'h8, 32'h1234);
      rd(4'h8);
      chk("count ro", v, 0);
      wr(4'h4, 0);
      wr(4'h0, 32'hffffff7f);
      rd(4'h0);
      chk("ctrl mask", v, 32'h0000c750);
      $display("test regs done");
      for (int s = 0; s < 4; s++)
         for (int c = 1; c < 8; c++) begin
            wr(4'h0, 32'(s * 16384 + c * 256 + 16));
            per(n);
            chk("period", n, exp_per(s, c, 0));
         end
      $display("test ratios done");
      for (int i = 0; i < 4; i++) begin
         n = $urandom_range(40, 1);
         wr(4'h4, 32'(n));
         wr(4'h0, 32'(16 + 256 * (1 + i % 2)));
         per(m);
         chk("wrap period", m, exp_per(0, 1 + i % 2, n));
         rd(4'h8);
         chk("count bound", 32'(v <= n), 1);
      end
      $display("test wrap done");
      wr(4'h0, 32'h0000c700);
      repeat (1100) @(posedge clk);
      rd(4'h8);
      chk("slow tick", v, 1);
      wr(4'h0, 32'h0000c600);
      rd(4'h8);
      chk("div restart", v, 0);
      wr(4'h0, 32'h00008600);
      repeat (300) @(posedge clk);
      rd(4'h8);
      chk("src tick", v, 1);
      wr(4'h0, 32'h00000600);
      rd(4'h8);
      chk("src restart", v, 0);
      $display("test restart done");
      wr(4'h4, 0);
      wr(4'h0, 32'h0000c140);
      repeat (300) @(posedge clk);
      wr(4'h0, 32'h0000c040);
      rd(4'h0);
      chk("flag sticky", v, 32'h0000c0c0);
      chk("irq on", 32'(irq), 1);
      wr(4'h0, 32'h0000c0c0);
      rd(4'h0);
      chk("flag clear", v, 32'h0000c040);
      chk("irq off", 32'(irq), 0);
      $display("test flag done");
      conclude();
   end
endmodule : tb_mwc_top
